// ### fcdm_pkg.sv
/*
 * Constants, register map and carrier types for the four-channel data mover.
 * Assumes an 8-bit register port and an 8-bit shared data bus with 16-bit addresses.
 */
package fcdm_pkg;

	localparam int NUM_CH = 4;

	// Global registers
	localparam logic [7:0] OFS_GCTRL   = 8'h00;
	localparam logic [7:0] OFS_INTSTAT = 8'h01;
	localparam logic [7:0] OFS_INTMASK = 8'h02;
	localparam logic [7:0] OFS_CHSTAT  = 8'h03;

	// Channel n occupies the 16-byte page (n + CH_PAGE_FIRST)
	localparam logic [3:0] CH_PAGE_FIRST = 4'h1;
	localparam logic [3:0] CH_PAGE_LAST  = 4'h4;
	localparam logic [3:0] OFS_CTRL      = 4'h0;
	localparam logic [3:0] OFS_ADDRCTRL  = 4'h1;
	localparam logic [3:0] OFS_TRIGSEL   = 4'h2;
	localparam logic [3:0] OFS_LENL      = 4'h3;
	localparam logic [3:0] OFS_LENH      = 4'h4;
	localparam logic [3:0] OFS_REP       = 4'h5;
	localparam logic [3:0] OFS_SRCL      = 4'h6;
	localparam logic [3:0] OFS_SRCH      = 4'h7;
	localparam logic [3:0] OFS_DSTL      = 4'h8;
	localparam logic [3:0] OFS_DSTH      = 4'h9;

	// Field positions
	localparam int GCTRL_RR       = 0;
	localparam int GCTRL_EEMAP    = 1;
	localparam int CTRL_EN        = 0;
	localparam int CTRL_SWTRIG    = 1;
	localparam int CTRL_BURST_LSB = 2;
	localparam int CTRL_RELOAD    = 4;
	localparam int CTRL_LINK      = 5;
	localparam int CTRL_PEND      = 6;
	localparam int ADDR_SRC_LSB   = 0;
	localparam int ADDR_DST_LSB   = 2;
	localparam int INT_DONE_LSB   = 0;
	localparam int INT_ERR_LSB    = 4;

	// Address step modes
	localparam logic [1:0] STEP_FIXED = 2'h0;
	localparam logic [1:0] STEP_INC   = 2'h1;
	localparam logic [1:0] STEP_DEC   = 2'h2;

	// Trigger selection codes
	localparam logic [3:0] TRIG_NONE        = 4'h0;
	localparam logic [3:0] TRIG_PERIPH_LAST = 4'h4;
	localparam logic [3:0] TRIG_EVENT_FIRST = 4'h8;

	// Data space map
	localparam logic [15:0] IO_LAST   = 16'h0fff;
	localparam logic [15:0] EE_BASE   = 16'h1000;
	localparam logic [15:0] EE_SIZE   = 16'h1000;
	localparam logic [15:0] SRAM_BASE = 16'h2000;
	localparam logic [15:0] SRAM_SIZE = 16'h4000;

	typedef enum logic [1:0] {
		REG_IO   = 2'b00,
		REG_EE   = 2'b01,
		REG_SRAM = 2'b10,
		REG_NONE = 2'b11
	} fcdm_region_e;

	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_CHECK = 3'b001,
		S_READ  = 3'b010,
		S_FETCH = 3'b011,
		S_WRITE = 3'b100
	} fcdm_fsm_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} fcdm_regreq_t;

	typedef struct packed {
		logic        req;
		logic        write;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} fcdm_memreq_t;

	typedef struct packed {
		logic        en;
		logic        pend;
		logic [1:0]  burstSel;
		logic        reload;
		logic        link;
		logic [1:0]  srcMode;
		logic [1:0]  dstMode;
		logic [3:0]  trigSel;
		logic [15:0] len;
		logic [7:0]  rep;
		logic [15:0] srcBase;
		logic [15:0] dstBase;
		logic [15:0] srcCur;
		logic [15:0] dstCur;
		logic [16:0] lenLeft;
		logic [8:0]  repLeft;
	} fcdm_chan_t;

	typedef struct packed {
		fcdm_chan_t [NUM_CH-1:0] ch;
		fcdm_fsm_e               fsm;
		logic [1:0]              act;
		logic [1:0]              lastServed;
		logic [3:0]              burstLeft;
		logic [15:0]             busAddr;
		logic [7:0]              busData;
		logic                    roundRobin;
		logic                    eeMap;
		logic [7:0]              intStat;
		logic [7:0]              intMask;
		logic [7:0]              rdData;
	} fcdm_state_t;

	localparam fcdm_state_t STATE_RESET = '0;

endpackage

// ### fcdm_mover.sv
/*
 * Four-channel byte mover that shares the processor's data bus.
 * Assumes register port, data bus grant, triggers and events all come from logic
 * on clk; read data of a granted bus read is valid in the following cycle.
 */
// Added by the designer: the register addresses and the address-and-strobe port.
// Notes on behaviour
// (RULE1) Four channels, each with its own independent configuration registers.
// (RULE2) Block length programmable from 1 to 65536 bytes; zero means 65536.
// (RULE3) Repeat count reruns the block up to 256 times, totalling 16M bytes.
// (RULE4) Source and destination each increment, decrement or stay fixed per byte.
// (RULE5) Optionally restore starting source and destination addresses at transaction end.
// (RULE6) Burst of 1, 2, 4 or 8 bytes moved per trigger.
// (RULE7) Software selects fixed or round-robin priority between channels.
// (RULE8) All moves use the shared data bus, waiting for its grant.
// (RULE9) Trigger per channel: peripheral request, event line or software; sets differ.
// (RULE10) Paired channels hand over to each other when a transaction ends.
// (RULE11) EEPROM only read through mapped window; never written; flash never reached.
// (RULE12) Any memory or peripheral may be source or destination.
// (RULE13) Peripherals reached only through I/O registers in data space.
// (RULE14) I/O at 0-FFF, EEPROM from 1000, SRAM from 2000 hexadecimal.
// (RULE15) EEPROM visible in data space only while mapping is enabled.
// (RULE16) Transaction end sets a readable, read-cleared done flag; channel idles unless linked; the code disables the channel even when linked.
// (RULE17) Illegal source or destination address sets an error flag and stops the channel.
`timescale 1ns/1ps

module fcdm_mover
	import fcdm_pkg::*;
(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         srst,
	// Register port
	input  wire fcdm_regreq_t regReq,
	output logic [7:0]        regRdata,
	// Shared data bus
	output fcdm_memreq_t      memReq,
	input  wire logic         memGnt,
	input  wire logic [7:0]   memRdata,
	// Transfer triggers, four peripheral requests per channel
	input  wire logic [15:0]  periphReq,
	input  wire logic [7:0]   eventIn,
	// Interrupt
	output logic              irq
);

	fcdm_state_t         st;
	fcdm_state_t         next_st;
	logic [NUM_CH-1:0]   trigHitV;
	logic [NUM_CH-1:0]   busyV;
	logic [NUM_CH-1:0]   cand;
	logic [1:0]          pick;
	fcdm_chan_t          cw;
	logic                badSrc;
	logic                badDst;

	// Data space decode; EEPROM only counts while mapped, flash is never in this space
	function automatic fcdm_region_e regionOf(input logic [15:0] a, input logic eeMap);
		if (a <= IO_LAST)
			return REG_IO; // RULE13 RULE14
		else if (a >= EE_BASE && a < 16'(EE_BASE + EE_SIZE))
			return eeMap ? REG_EE : REG_NONE; // RULE14 RULE15
		else if (a >= SRAM_BASE && a < 16'(SRAM_BASE + SRAM_SIZE))
			return REG_SRAM; // RULE14
		else
			return REG_NONE;
	endfunction

	function automatic logic [15:0] stepAddr(input logic [15:0] a, input logic [1:0] mode);
		if (mode == STEP_INC)
			return 16'(a + 16'h0001); // RULE4
		else if (mode == STEP_DEC)
			return 16'(a - 16'h0001); // RULE4
		else
			return a;
	endfunction

	function automatic logic chanHit(input logic [7:0] a);
		return (a[7:4] >= CH_PAGE_FIRST) && (a[7:4] <= CH_PAGE_LAST);
	endfunction

	function automatic logic [1:0] chanIdx(input logic [7:0] a);
		return 2'(a[7:4] - CH_PAGE_FIRST);
	endfunction

	function automatic logic [16:0] lenLoad(input logic [15:0] l);
		return {(l == 16'h0000), l}; // RULE2
	endfunction

	function automatic logic [8:0] repLoad(input logic [7:0] r);
		return {(r == 8'h00), r}; // RULE3
	endfunction

	function automatic logic trigHit(input logic [1:0] c, input logic [3:0] sel,
			input logic [15:0] periph, input logic [7:0] evt);
		if (sel >= TRIG_EVENT_FIRST)
			return evt[sel[2:0]]; // RULE9
		else if (sel != TRIG_NONE && sel <= TRIG_PERIPH_LAST)
			return periph[{c, 2'(sel - 4'h1)}]; // RULE9
		else
			return 1'b0;
	endfunction

	function automatic logic [1:0] pickChannel(input logic [NUM_CH-1:0] c, input logic rr,
			input logic [1:0] last);
		logic [1:0] k;
		logic [1:0] res;
		logic       found;
		res = 2'h0;
		found = 1'b0;
		for (int i = 0; i < NUM_CH; i++) begin
			k = rr ? 2'(last + 2'(i + 1)) : 2'(i); // RULE7
			if (!found && c[k]) begin
				res = k;
				found = 1'b1;
			end
		end
		return res;
	endfunction

	function automatic logic [7:0] chanRead(input fcdm_chan_t c, input logic [3:0] ofs);
		logic [7:0] v;
		v = 8'h00;
		if (ofs == OFS_CTRL) begin
			v[CTRL_EN] = c.en;
			v[CTRL_BURST_LSB +: 2] = c.burstSel;
			v[CTRL_RELOAD] = c.reload;
			v[CTRL_LINK] = c.link;
			v[CTRL_PEND] = c.pend;
		end else if (ofs == OFS_ADDRCTRL) begin
			v[ADDR_SRC_LSB +: 2] = c.srcMode;
			v[ADDR_DST_LSB +: 2] = c.dstMode;
		end else if (ofs == OFS_TRIGSEL)
			v[3:0] = c.trigSel;
		else if (ofs == OFS_LENL)
			v = c.len[7:0];
		else if (ofs == OFS_LENH)
			v = c.len[15:8];
		else if (ofs == OFS_REP)
			v = c.rep;
		else if (ofs == OFS_SRCL)
			v = c.srcCur[7:0];
		else if (ofs == OFS_SRCH)
			v = c.srcCur[15:8];
		else if (ofs == OFS_DSTL)
			v = c.dstCur[7:0];
		else if (ofs == OFS_DSTH)
			v = c.dstCur[15:8];
		return v;
	endfunction

	// Address writes load both the start copy and the working pointer
	function automatic fcdm_chan_t chanWrite(input fcdm_chan_t c, input logic [3:0] ofs,
			input logic [7:0] d);
		fcdm_chan_t r;
		r = c;
		if (ofs == OFS_CTRL) begin
			r.en = d[CTRL_EN];
			r.burstSel = d[CTRL_BURST_LSB +: 2]; // RULE6
			r.reload = d[CTRL_RELOAD];
			r.link = d[CTRL_LINK];
			r.pend = d[CTRL_EN] & (c.pend | d[CTRL_SWTRIG]); // RULE9
		end else if (ofs == OFS_ADDRCTRL) begin
			r.srcMode = d[ADDR_SRC_LSB +: 2];
			r.dstMode = d[ADDR_DST_LSB +: 2];
		end else if (ofs == OFS_TRIGSEL)
			r.trigSel = d[3:0];
		else if (ofs == OFS_LENL) begin
			r.len[7:0] = d;
			r.lenLeft = lenLoad({c.len[15:8], d});
		end else if (ofs == OFS_LENH) begin
			r.len[15:8] = d;
			r.lenLeft = lenLoad({d, c.len[7:0]});
		end else if (ofs == OFS_REP) begin
			r.rep = d;
			r.repLeft = repLoad(d);
		end else if (ofs == OFS_SRCL) begin
			r.srcBase[7:0] = d;
			r.srcCur[7:0] = d;
		end else if (ofs == OFS_SRCH) begin
			r.srcBase[15:8] = d;
			r.srcCur[15:8] = d;
		end else if (ofs == OFS_DSTL) begin
			r.dstBase[7:0] = d;
			r.dstCur[7:0] = d;
		end else if (ofs == OFS_DSTH) begin
			r.dstBase[15:8] = d;
			r.dstCur[15:8] = d;
		end
		return r;
	endfunction

	// Each channel sees its own slice of peripheral requests
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : gChan
			assign trigHitV[g] = trigHit(2'(g), st.ch[g].trigSel, periphReq, eventIn);
			assign busyV[g] = (st.fsm != S_IDLE) && (st.act == 2'(g));
			assign cand[g] = st.ch[g].en && st.ch[g].pend; // RULE1
		end
	endgenerate

	assign pick = pickChannel(cand, st.roundRobin, st.lastServed);
	assign badSrc = (regionOf(st.ch[st.act].srcCur, st.eeMap) == REG_NONE); // RULE11 RULE17
	assign badDst = (regionOf(st.ch[st.act].dstCur, st.eeMap) == REG_NONE)
		|| (regionOf(st.ch[st.act].dstCur, st.eeMap) == REG_EE); // RULE11 RULE17

	always_comb begin
		next_st = st;
		next_st.rdData = 8'h00;
		cw = st.ch[st.act];

		// Register reads; a status read clears it before any new event is merged
		if (regReq.rd) begin
			if (regReq.addr == OFS_GCTRL) begin
				next_st.rdData[GCTRL_RR] = st.roundRobin;
				next_st.rdData[GCTRL_EEMAP] = st.eeMap;
			end else if (regReq.addr == OFS_INTSTAT) begin
				next_st.rdData = st.intStat; // RULE16
				next_st.intStat = 8'h00; // RULE16
			end else if (regReq.addr == OFS_INTMASK)
				next_st.rdData = st.intMask;
			else if (regReq.addr == OFS_CHSTAT)
				next_st.rdData = {busyV, cand};
			else if (chanHit(regReq.addr))
				next_st.rdData = chanRead(st.ch[chanIdx(regReq.addr)], regReq.addr[3:0]);
		end

		// Register writes
		if (regReq.wr) begin
			if (regReq.addr == OFS_GCTRL) begin
				next_st.roundRobin = regReq.wdata[GCTRL_RR]; // RULE7
				next_st.eeMap = regReq.wdata[GCTRL_EEMAP]; // RULE15
			end else if (regReq.addr == OFS_INTMASK)
				next_st.intMask = regReq.wdata;
			else if (chanHit(regReq.addr))
				next_st.ch[chanIdx(regReq.addr)] = chanWrite(st.ch[chanIdx(regReq.addr)],
					regReq.addr[3:0], regReq.wdata);
		end

		case (st.fsm)
			S_IDLE: begin
				if (|cand) begin
					next_st.act = pick; // RULE7
					next_st.lastServed = pick;
					next_st.burstLeft = 4'(4'h1 << st.ch[pick].burstSel); // RULE6
					next_st.fsm = S_CHECK;
				end
			end
			S_CHECK: begin
				// Checked per byte because pointers move during a burst
				if (badSrc || badDst) begin
					next_st.intStat[INT_ERR_LSB + int'(st.act)] = 1'b1; // RULE17
					next_st.ch[st.act].en = 1'b0; // RULE17
					next_st.ch[st.act].pend = 1'b0;
					next_st.fsm = S_IDLE;
				end else begin
					next_st.busAddr = st.ch[st.act].srcCur; // RULE12
					next_st.fsm = S_READ;
				end
			end
			S_READ: begin
				if (memGnt)
					next_st.fsm = S_FETCH; // RULE8
			end
			S_FETCH: begin
				next_st.busData = memRdata;
				next_st.busAddr = st.ch[st.act].dstCur;
				next_st.fsm = S_WRITE;
			end
			S_WRITE: begin
				if (memGnt) begin // RULE8
					cw.srcCur = stepAddr(cw.srcCur, cw.srcMode); // RULE4
					cw.dstCur = stepAddr(cw.dstCur, cw.dstMode); // RULE4
					cw.lenLeft = 17'(cw.lenLeft - 17'h00001);
					next_st.burstLeft = 4'(st.burstLeft - 4'h1);
					next_st.fsm = S_CHECK;
					if (st.ch[st.act].lenLeft == 17'h00001) begin
						cw.lenLeft = lenLoad(cw.len); // RULE2
						cw.pend = 1'b0;
						next_st.fsm = S_IDLE;
						if (st.ch[st.act].repLeft == 9'h001) begin
							cw.repLeft = repLoad(cw.rep); // RULE3
							cw.en = 1'b0; // RULE16
							next_st.intStat[INT_DONE_LSB + int'(st.act)] = 1'b1; // RULE16
							if (cw.reload) begin
								cw.srcCur = cw.srcBase; // RULE5
								cw.dstCur = cw.dstBase; // RULE5
							end
						end else
							cw.repLeft = 9'(cw.repLeft - 9'h001); // RULE3
					end else if (st.burstLeft == 4'h1) begin
						cw.pend = 1'b0; // RULE6
						next_st.fsm = S_IDLE;
					end
					next_st.ch[st.act] = cw;
					// Partner takes over; it still waits for its own trigger
					if (st.ch[st.act].lenLeft == 17'h00001 && st.ch[st.act].repLeft == 9'h001
							&& cw.link)
						next_st.ch[st.act ^ 2'h1].en = 1'b1; // RULE10
				end
			end
			default: next_st.fsm = S_IDLE;
		endcase

		// Trigger set comes last so it wins over a clear in the same cycle
		for (int i = 0; i < NUM_CH; i++) begin
			if (trigHitV[i] && next_st.ch[i].en)
				next_st.ch[i].pend = 1'b1; // RULE9
		end
	end

	always_ff @(posedge clk) begin
		if (srst)
			st <= STATE_RESET;
		else
			st <= next_st;
	end

	assign regRdata = st.rdData;
	assign memReq.req = (st.fsm == S_READ) || (st.fsm == S_WRITE); // RULE8
	assign memReq.write = (st.fsm == S_WRITE);
	assign memReq.addr = st.busAddr;
	assign memReq.wdata = st.busData;
	assign irq = |(st.intStat & st.intMask);

endmodule

// ### fcdm_mover_chk.sv
/* Bus and register port checks for the data mover.
   Assumes binding to fcdm_mover; sees its ports only. */
`timescale 1ns/1ps
module fcdm_mover_chk
	import fcdm_pkg::*;
(
	// Clock and reset
	input wire logic         clk,
	input wire logic         srst,
	// Watched ports
	input wire fcdm_regreq_t regReq,
	input wire logic [7:0]   regRdata,
	input wire fcdm_memreq_t memReq,
	input wire logic         memGnt,
	input wire logic [7:0]   memRdata,
	input wire logic         irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	logic rdGo;
	logic wrGo;
	assign rdGo = memReq.req && !memReq.write && memGnt;
	assign wrGo = memReq.req && memReq.write && memGnt;
	AST_RDATA_IDLE: assert property (!$past(regReq.rd) |-> regRdata == 8'h00)
		else $error("read data not idle");
	AST_NO_EE_WRITE: assert property (memReq.req && memReq.write |->
		memReq.addr < EE_BASE || memReq.addr >= SRAM_BASE) else $error("EEPROM write");
	AST_MAPPED_ONLY: assert property (memReq.req |-> memReq.addr < 16'h6000)
		else $error("unmapped access");
	AST_HOLD_REQ: assert property (memReq.req && !memGnt |=> memReq.req
		&& $stable(memReq.addr) && $stable(memReq.write)) else $error("request dropped");
	AST_READ_WRITE: assert property (rdGo |=> !memReq.req ##1 memReq.write)
		else $error("read not followed by write");
	AST_WDATA_SRC: assert property (rdGo ##1 1'b1 |=> memReq.wdata == $past(memRdata))
		else $error("wrong write data");
	AST_WRITE_GAP: assert property (wrGo |=> !memReq.req)
		else $error("no check cycle");
	AST_MASK_OFF: assert property (regReq.wr && regReq.addr == OFS_INTMASK
		&& regReq.wdata == 8'h00 |=> !irq) else $error("masked irq");
	cover property (wrGo);
	cover property ($rose(irq));
	cover property (memReq.req && !memGnt);
endmodule
bind fcdm_mover fcdm_mover_chk i_chk (.clk(clk), .srst(srst), .regReq(regReq),
	.regRdata(regRdata), .memReq(memReq), .memGnt(memGnt), .memRdata(memRdata), .irq(irq));

// ### fcdm_mem_model.sv
/* Shared data bus model: arbiter grant and memory.
   Assumes one requester on clk; read data the cycle after grant. */
`timescale 1ns/1ps
module fcdm_mem_model
	import fcdm_pkg::*;
(
	// Clock and reset
	input wire logic         clk,
	input wire logic         srst,
	// Bus
	input wire fcdm_memreq_t memReq,
	output logic             memGnt,
	output logic [7:0]       memRdata,
	// Control
	input wire logic         slow
);
	logic [7:0] mem [0:24575];
	logic       tick;
	// Slow grants every other cycle, as a busy processor would
	assign memGnt = memReq.req && (!slow || tick);
	always @(posedge clk) begin
		tick <= srst ? 1'b0 : !tick;
		if (srst) begin
			memRdata <= 8'h00;
		end else if (memGnt && !memReq.write && memReq.addr < 16'h6000) begin
			memRdata <= mem[memReq.addr];
		end else begin
			// No stale byte outside the answer cycle
			memRdata <= ~memRdata;
		end
		if (!srst && memGnt && memReq.write && memReq.addr < 16'h6000) begin
			mem[memReq.addr] <= memReq.wdata;
		end
	end
endmodule

// ### tb.sv
/* Self-checking bench for the data mover.
   Assumes the bus model holds preloaded bytes. */
`timescale 1ns/1ps
module tb
	import fcdm_pkg::*;
;
	logic         clk;
	logic         srst;
	fcdm_regreq_t regReq;
	logic [7:0]   regRdata;
	fcdm_memreq_t memReq;
	logic         memGnt;
	logic [7:0]   memRdata;
	logic [15:0]  periphReq;
	logic [7:0]   eventIn;
	logic         irq;
	logic         slow;
	int           fails;
	int           checkCount;
	fcdm_mover i_dut (.clk(clk), .srst(srst), .regReq(regReq), .regRdata(regRdata),
		.memReq(memReq), .memGnt(memGnt), .memRdata(memRdata), .periphReq(periphReq),
		.eventIn(eventIn), .irq(irq));
	fcdm_mem_model i_mem (.clk(clk), .srst(srst), .memReq(memReq), .memGnt(memGnt),
		.memRdata(memRdata), .slow(slow));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic closeOut();
		$display("checks %0d mismatches %0d", checkCount, fails);
		if (fails == 0 && checkCount > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checkCount++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		regReq <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		regReq <= '0;
		#1 chk(regRdata, exp);
	endtask
	task automatic cfg(input logic [1:0] c, input logic [7:0] ctl, input logic [7:0] am,
		input logic [3:0] ts, input logic [15:0] ln, input logic [7:0] rp,
		input logic [15:0] s, input logic [15:0] d);
		logic [7:0] v [1:9];
		v = '{am, {4'h0, ts}, ln[7:0], ln[15:8], rp, s[7:0], s[15:8], d[7:0], d[15:8]};
		for (int i = 1; i <= 9; i++) begin
			wr({CH_PAGE_FIRST + 4'(c), 4'(i)}, v[i]);
		end
		// Enable last, so no burst starts on half-written settings
		wr({CH_PAGE_FIRST + 4'(c), OFS_CTRL}, ctl);
	endtask
	task automatic waitIrq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		if (irq !== 1'b1) begin
			fails++;
			$display("mismatch at %0t: no interrupt", $time);
			closeOut();
		end
	endtask
	initial begin
		srst = 1'b1;
		regReq = '0;
		periphReq = '0;
		eventIn = '0;
		slow = 1'b0;
		fails = 0;
		checkCount = 0;
		for (int i = 0; i < 4; i++) begin
			i_mem.mem[16'h2000 + i] = 8'ha0 + 8'(i);
			i_mem.mem[16'h2100 + i] = 8'h50 + 8'(i);
		end
		i_mem.mem[EE_BASE] = 8'h77;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		#1 chk({7'h00, irq}, 8'h00);
		rd(8'hff, 8'h00);
		rd(OFS_GCTRL, 8'h00);
		wr(OFS_INTMASK, 8'hff);
		// Four-byte burst on one trigger while the bus stalls
		slow <= 1'b1;
		cfg(2'd0, 8'h0b, 8'h05, TRIG_NONE, 16'd4, 8'd1, 16'h2000, 16'h3000);
		waitIrq();
		for (int i = 0; i < 4; i++) begin
			chk(i_mem.mem[16'h3000 + i], 8'ha0 + 8'(i));
		end
		rd(OFS_INTSTAT, 8'h01);
		rd(OFS_INTSTAT, 8'h00);
		// Held peripheral request, two blocks, falling source into an I/O register
		slow <= 1'b0;
		cfg(2'd1, 8'h11, 8'h02, 4'h1, 16'd2, 8'd2, 16'h2103, 16'h0040);
		periphReq <= 16'h0010;
		waitIrq();
		periphReq <= 16'h0000;
		chk(i_mem.mem[16'h0040], 8'h50);
		rd({4'h2, OFS_SRCL}, 8'h03);
		rd({4'h2, OFS_SRCH}, 8'h21);
		rd(OFS_INTSTAT, 8'h02);
		// EEPROM as destination
		cfg(2'd2, 8'h03, 8'h05, TRIG_NONE, 16'd1, 8'd1, 16'h2000, EE_BASE);
		waitIrq();
		rd(OFS_INTSTAT, 8'h40);
		chk(i_mem.mem[EE_BASE], 8'h77);
		// EEPROM source while unmapped, then mapped on an event line
		cfg(2'd3, 8'h03, 8'h00, TRIG_NONE, 16'd1, 8'd1, EE_BASE, 16'h2200);
		waitIrq();
		rd(OFS_INTSTAT, 8'h80);
		wr(OFS_GCTRL, 8'h02);
		cfg(2'd3, 8'h01, 8'h00, TRIG_EVENT_FIRST, 16'd1, 8'd1, EE_BASE, 16'h2200);
		@(posedge clk);
		eventIn <= 8'h01;
		@(posedge clk);
		eventIn <= 8'h00;
		waitIrq();
		chk(i_mem.mem[16'h2200], 8'h77);
		rd(OFS_INTSTAT, 8'h08);
		// Linked pair: channel 1 waits disabled until channel 0 finishes
		cfg(2'd1, 8'h00, 8'h05, TRIG_NONE, 16'd1, 8'd1, 16'h2000, 16'h2300);
		cfg(2'd0, 8'h23, 8'h05, TRIG_NONE, 16'd1, 8'd1, 16'h2000, 16'h2300);
		waitIrq();
		rd(OFS_INTSTAT, 8'h01);
		rd({4'h1, OFS_CTRL}, 8'h20);
		rd({4'h2, OFS_CTRL}, 8'h01);
		chk(i_mem.mem[16'h2300], 8'ha0);
		closeOut();
	end
endmodule
